// File: hw/pio_pin_cell.sv
/*
 one group of port pins: latch, direction, read mux and driver controls.
 assumes pins are synchronous to sys_clk and a two-way pin resolves outside.
*/
`timescale 1ns/1ps
module pio_pin_cell
  import pio_pkg::*;
#(
  parameter int W = 8,
  parameter bit OPEN_DRAIN = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_latch,
  input wire logic wr_dir,
  input wire logic [W-1:0] wdata,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] in_gate,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] rdata,
  output logic [W-1:0] dir
);
  import pio_pkg::*;

  logic [W-1:0] latch_q;
  logic [W-1:0] latch_d;
  logic [W-1:0] dir_q;
  logic [W-1:0] dir_d;

  // only widths up to one byte fit the 8-bit register word
  if (W < 1 || W > PIO_PORT_W)
  begin : g_bad_width
    $error("pio_pin_cell width out of range");
  end

  always_comb
  begin
    latch_d = latch_q;
    dir_d = dir_q;
    if (wr_latch)
      latch_d = wdata;
    if (wr_dir)
      dir_d = wdata;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      latch_q <= PIO_RST_LATCH[W-1:0];
      dir_q <= PIO_RST_DIR[W-1:0];
    end
    else
    begin
      latch_q <= latch_d;
      dir_q <= dir_d;
    end
  end

  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      // input mode: pin level through its gate; output mode: the latch
      rdata[i] = dir_q[i] ? latch_q[i] : (pin_in[i] & in_gate[i]);
      if (OPEN_DRAIN)
      begin
        pin_out[i] = 1'b0;
        pin_oe[i] = dir_q[i] & ~latch_q[i];
      end
      else
      begin
        pin_out[i] = latch_q[i];
        pin_oe[i] = dir_q[i];
      end
    end
  end

  assign dir = dir_q;

  a_dir_reset_zero: assert property (@(posedge sys_clk)
    $rose(arst_n) |-> dir_q == '0)
    else $error("direction not cleared by reset");
  a_latch_keeps: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (wr_dir && !wr_latch) |=> latch_q == $past(latch_q))
    else $error("latch changed on direction write");
  a_out_read_latch: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (dir_q[0] && !wr_latch && !wr_dir) |=> rdata[0] == latch_q[0])
    else $error("output read not from latch");
  a_in_no_drive: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    !dir_q[0] |-> !pin_oe[0])
    else $error("input pin driven");
endmodule

// File: hw/pio_pullup.sv
/*
 pull-up enables for ports a and b from control, direction and serial use.
 assumes the serial block reports which port b serial pins it owns.
*/
`timescale 1ns/1ps
module pio_pullup
  import pio_pkg::*;
(
  input wire logic [7:0] pull_a,
  input wire logic [7:0] pull_b,
  input wire logic [7:0] dir_a,
  input wire logic [7:0] dir_b,
  input wire logic [PIO_SER_W-1:0] serial_use,
  output logic [7:0] pu_a,
  output logic [7:0] pu_b
);
  import pio_pkg::*;

  logic lo_on;
  logic hi_on;
  logic [7:0] ser_mask;

  always_comb
  begin
    lo_on = |pull_b[PIO_NIB_LO +: 4];
    hi_on = |pull_b[PIO_NIB_HI +: 4];
    ser_mask = '0;
    ser_mask[PIO_SER_LSB +: PIO_SER_W] = serial_use;
    pu_a = pull_a & ~dir_a;
    pu_b = {{4{hi_on}}, {4{lo_on}}} & ~dir_b & ~ser_mask;
  end
endmodule

// File: hw/pio_top.sv
/*
 programmable port block: six ports (a, b, c byte-wide; d, e, f four bits) behind an AHB-Lite slave.
 assumes one master, single word transfers, pins synchronous to sys_clk.
 the slave never inserts wait states; every access gets OKAY.
*/
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module pio_top
  import pio_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_a_pullup,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_pullup,
  input wire logic [7:0] port_c_in,
  input wire logic [3:0] port_d_in,
  input wire logic [3:0] port_e_in,
  output logic [3:0] port_e_out,
  output logic [3:0] port_e_oe,
  input wire logic [3:0] port_f_in,
  output logic [3:0] port_f_out,
  output logic [3:0] port_f_oe
);
  import pio_pkg::*;

  localparam int EW = LARGE_VARIANT ? PIO_E_W_LARGE : PIO_E_W_SMALL;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic wr_pend_q;
  logic wr_pend_d;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_addr_d;
  logic [7:0] rd_addr_q;
  logic [7:0] rd_addr_d;
  logic rd_pend_q;
  logic rd_pend_d;
  logic take;

  assign take = hsel && hready && htrans[1];

  always_comb
  begin
    wr_pend_d = take && hwrite;
    rd_pend_d = take && !hwrite;
    wr_addr_d = take ? {haddr[7:2], 2'b00} : wr_addr_q;
    rd_addr_d = take ? {haddr[7:2], 2'b00} : rd_addr_q;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      wr_addr_q <= wr_addr_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  // zero wait states: answer always ready and okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // an unaligned code while idle, so no register ever matches it; the
  // offset travels as an argument so every caller re-evaluates on change
  logic [7:0] wr_ofs;
  assign wr_ofs = wr_pend_q ? wr_addr_q : 8'hff;

  function automatic logic wr_hit(input logic [7:0] wa,
    input logic [7:0] ofs);
    wr_hit = (wa == ofs);
  endfunction

  // ----------------------------------------------------------------
  // control registers of our own
  // ----------------------------------------------------------------
  logic [7:0] pull_a_q;
  logic [7:0] pull_a_d;
  logic [7:0] pull_b_q;
  logic [7:0] pull_b_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [PIO_SER_W-1:0] ser_q;
  logic [PIO_SER_W-1:0] ser_d;

  always_comb
  begin
    pull_a_d = pull_a_q;
    pull_b_d = pull_b_q;
    ctrl_d = ctrl_q;
    ser_d = ser_q;
    if (wr_hit(wr_ofs, PIO_OFS_PULL_A))
      pull_a_d = hwdata[7:0];
    if (wr_hit(wr_ofs, PIO_OFS_PULL_B))
      pull_b_d = hwdata[7:0];
    if (wr_hit(wr_ofs, PIO_OFS_UPPER_CTRL))
      ctrl_d = hwdata[7:0];
    if (wr_hit(wr_ofs, PIO_OFS_SERIAL))
      ser_d = hwdata[PIO_SER_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pull_a_q <= PIO_RST_PULL;
      pull_b_q <= PIO_RST_PULL;
      ctrl_q <= PIO_RST_CTRL;
      ser_q <= '0;
    end
    else
    begin
      pull_a_q <= pull_a_d;
      pull_b_q <= pull_b_d;
      ctrl_q <= ctrl_d;
      ser_q <= ser_d;
    end
  end

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] dir_a;
  logic [7:0] dir_b;
  logic [EW-1:0] rd_e;
  logic [EW-1:0] dir_e;
  logic [EW-1:0] e_out;
  logic [EW-1:0] e_oe;
  logic [EW-1:0] e_gate;
  logic [PIO_F_W-1:0] rd_f;
  logic [PIO_F_W-1:0] dir_f;
  logic [PIO_F_W-1:0] f_out;
  logic [PIO_F_W-1:0] f_oe;
  logic [PIO_F_W-1:0] f_gate;

  pio_pin_cell #(.W(8), .OPEN_DRAIN(1'b0)) u_port_a (
    .sys_clk(sys_clk), .arst_n(arst_n),
    // latches and directions load at the edge that ends the data phase
    .wr_latch(wr_hit(wr_ofs, PIO_OFS_PORT_A)),
    .wr_dir(wr_hit(wr_ofs, PIO_OFS_DIR_A)),
    .wdata(hwdata[7:0]), .pin_in(port_a_in), .in_gate(8'hff),
    .pin_out(port_a_out), .pin_oe(port_a_oe), .rdata(rd_a), .dir(dir_a));

  pio_pin_cell #(.W(8), .OPEN_DRAIN(1'b0)) u_port_b (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .wr_latch(wr_hit(wr_ofs, PIO_OFS_PORT_B)),
    .wr_dir(wr_hit(wr_ofs, PIO_OFS_DIR_B)),
    .wdata(hwdata[7:0]), .pin_in(port_b_in), .in_gate(8'hff),
    .pin_out(port_b_out), .pin_oe(port_b_oe), .rdata(rd_b), .dir(dir_b));

  // upper e pins read only with their input-control bit set
  always_comb
  begin
    e_gate = '1;
    if (EW > 2)
      e_gate[EW-1:EW-2] = ctrl_q[PIO_CTRL_E_LSB +: 2];
    f_gate = LARGE_VARIANT ? ctrl_q[PIO_CTRL_F_LSB +: PIO_F_W]
                           : 4'h0;
  end

  pio_pin_cell #(.W(EW), .OPEN_DRAIN(1'b1)) u_port_e (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .wr_latch(wr_hit(wr_ofs, PIO_OFS_PORT_E)),
    .wr_dir(wr_hit(wr_ofs, PIO_OFS_DIR_E)),
    .wdata(hwdata[EW-1:0]), .pin_in(port_e_in[EW-1:0]), .in_gate(e_gate),
    .pin_out(e_out), .pin_oe(e_oe), .rdata(rd_e), .dir(dir_e));

  pio_pin_cell #(.W(PIO_F_W), .OPEN_DRAIN(1'b1)) u_port_f (
    .sys_clk(sys_clk), .arst_n(arst_n),
    // port f is absent on the small variant, so its writes are dropped
    .wr_latch(LARGE_VARIANT && wr_hit(wr_ofs, PIO_OFS_PORT_F)),
    .wr_dir(LARGE_VARIANT && wr_hit(wr_ofs, PIO_OFS_DIR_F)),
    .wdata(hwdata[PIO_F_W-1:0]), .pin_in(port_f_in), .in_gate(f_gate),
    .pin_out(f_out), .pin_oe(f_oe), .rdata(rd_f), .dir(dir_f));

  always_comb
  begin
    port_e_out = '0;
    port_e_oe = '0;
    port_e_out[EW-1:0] = e_out;
    port_e_oe[EW-1:0] = e_oe;
    port_f_out = f_out;
    port_f_oe = LARGE_VARIANT ? f_oe : 4'h0;
  end

  pio_pullup u_pullup (
    .pull_a(pull_a_q), .pull_b(pull_b_q), .dir_a(dir_a), .dir_b(dir_b),
    .serial_use(ser_q), .pu_a(port_a_pullup), .pu_b(port_b_pullup));

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;

  // pins are sampled at the address-phase edge; the word then stands for
  // the whole data phase and the bus sees zero at every other time

  always_comb
  begin
    hrdata_d = 32'h0000_0000;
    if (take && !hwrite)
    begin
      unique case ({haddr[7:2], 2'b00})
        PIO_OFS_PORT_A: hrdata_d[7:0] = rd_a;
        PIO_OFS_DIR_A: hrdata_d[7:0] = dir_a;
        PIO_OFS_PORT_B: hrdata_d[7:0] = rd_b;
        PIO_OFS_DIR_B: hrdata_d[7:0] = dir_b;
        PIO_OFS_PORT_C: hrdata_d[7:0] = port_c_in;
        PIO_OFS_PORT_D: hrdata_d[3:0] = port_d_in;
        PIO_OFS_PORT_E: hrdata_d[EW-1:0] = rd_e;
        PIO_OFS_DIR_E: hrdata_d[EW-1:0] = dir_e;
        PIO_OFS_PORT_F: hrdata_d[3:0] = LARGE_VARIANT ? rd_f : 4'h0;
        PIO_OFS_DIR_F: hrdata_d[3:0] = LARGE_VARIANT ? dir_f : 4'h0;
        PIO_OFS_PULL_A: hrdata_d[7:0] = pull_a_q;
        PIO_OFS_PULL_B: hrdata_d[7:0] = pull_b_q;
        PIO_OFS_UPPER_CTRL: hrdata_d[7:0] = ctrl_q;
        PIO_OFS_SERIAL: hrdata_d[PIO_SER_W-1:0] = ser_q;
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      hrdata_q <= 32'h0000_0000;
    else
      hrdata_q <= hrdata_d;
  end

  assign hrdata = hrdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_b_nibble_pull: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (|pull_b_q[3:0] && dir_b[3:0] == 4'h0) |-> port_b_pullup[3:0] == 4'hf)
    else $error("port b low nibble not pulled together");

  a_serial_no_pull: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    ser_q[0] |-> !port_b_pullup[PIO_SER_LSB])
    else $error("pull-up on serial pin");

  a_od_release: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    dir_e[0] |-> (port_e_oe[0] == !rd_e[0] && port_e_out == 4'h0))
    else $error("open-drain pin drive wrong");

  a_write_to_oe: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (wr_hit(wr_ofs, PIO_OFS_PORT_A) && dir_a[0]) |=>
    (port_a_oe[0] && port_a_out[0] == $past(hwdata[0])))
    else $error("written value not driven");

  a_pull_off_out: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (port_a_pullup & dir_a) == 8'h00 && (port_b_pullup & dir_b) == 8'h00)
    else $error("pull-up active on output pin");

  a_read_idle_zero: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    !rd_pend_q |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");

  a_c_read_pin: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (rd_pend_q && rd_addr_q == PIO_OFS_PORT_C) |->
    hrdata[7:0] == $past(port_c_in))
    else $error("port c read not from pins");

  a_a_read_mux: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    (rd_pend_q && rd_addr_q == PIO_OFS_PORT_A) |->
    hrdata[7:0] == $past((dir_a & port_a_out) | (~dir_a & port_a_in)))
    else $error("port a read mux wrong");

  a_variant_off: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    !LARGE_VARIANT |-> (port_f_oe == 4'h0 && port_e_oe[3:2] == 2'h0))
    else $error("absent pin driven on small variant");
endmodule

// File: shared/pio_pkg.sv
/*
 package of the programmable port block: register byte offsets, reset values,
 port widths and pull-up group layout.
 assumes a single 32-bit AHB-Lite slave decode with word-aligned registers.
*/
package pio_pkg;
  localparam logic [7:0] PIO_OFS_PORT_A = 8'h00;
  localparam logic [7:0] PIO_OFS_DIR_A = 8'h04;
  localparam logic [7:0] PIO_OFS_PORT_B = 8'h08;
  localparam logic [7:0] PIO_OFS_DIR_B = 8'h0c;
  localparam logic [7:0] PIO_OFS_PORT_C = 8'h10;
  localparam logic [7:0] PIO_OFS_PORT_D = 8'h14;
  localparam logic [7:0] PIO_OFS_PORT_E = 8'h18;
  localparam logic [7:0] PIO_OFS_DIR_E = 8'h1c;
  localparam logic [7:0] PIO_OFS_PORT_F = 8'h20;
  localparam logic [7:0] PIO_OFS_DIR_F = 8'h24;
  localparam logic [7:0] PIO_OFS_PULL_A = 8'h28;
  localparam logic [7:0] PIO_OFS_PULL_B = 8'h2c;
  localparam logic [7:0] PIO_OFS_UPPER_CTRL = 8'h30;
  localparam logic [7:0] PIO_OFS_SERIAL = 8'h34;
  localparam logic [7:0] PIO_RST_DIR = 8'h00;
  localparam logic [7:0] PIO_RST_LATCH = 8'h00;
  localparam logic [7:0] PIO_RST_PULL = 8'h00;
  localparam logic [7:0] PIO_RST_CTRL = 8'h00;
  localparam int PIO_PORT_W = 8;
  localparam int PIO_E_W_LARGE = 4;
  localparam int PIO_E_W_SMALL = 2;
  localparam int PIO_F_W = 4;
  // upper-control bit layout: bits 0..1 port e pins 2..3, bits 2..5 port f
  localparam int PIO_CTRL_E_LSB = 0;
  localparam int PIO_CTRL_F_LSB = 2;
  localparam int PIO_NIB_LO = 0;
  localparam int PIO_NIB_HI = 4;
  localparam int PIO_SER_LSB = 5;
  localparam int PIO_SER_W = 3;
endpackage

// File: tb/pio_pin_model.sv
/*
 external circuitry on one port: resolves each pin from driver, pull-up
 and an optional external source.
 assumes the bench moves ext and ext_en just after rising edges.
*/
`timescale 1ns/1ps
module pio_pin_model
#(
  parameter int W = 8,
  parameter bit OD = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pu,
  input wire logic [W-1:0] ext,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin
);
  logic tgl_q = 1'b0;
  always @(posedge sys_clk)
    tgl_q <= ~tgl_q;
  // an enabled source beats the driver: it stands for a heavy load
  // floating lines toggle, so a stale value never passes for a read
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (ext_en[i])
        pin[i] = ext[i];
      else if (oe[i])
        pin[i] = OD ? 1'b0 : out[i];
      else if (pu[i])
        pin[i] = 1'b1;
      else
        pin[i] = tgl_q ^ i[0];
    end
  end
endmodule

// File: tb/programmable_io_ports_tb.sv
/*
 self-checking bench of the port block: bus tasks, pin models, scenarios.
 assumes the slave answers with hreadyout and registered read data.
*/
`timescale 1ns/1ps
module programmable_io_ports_tb;
  import pio_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] a_out, a_oe, a_pu, a_pin, b_out, b_oe, b_pu, b_pin;
  logic [3:0] e_out, e_oe, e_pin, f_out, f_oe, f_pin;
  logic [7:0] a_ext = 8'h00, a_en = 8'h00, c_in = 8'h00;
  logic [3:0] d_in = 4'h0, e_ext = 4'h0, e_en = 4'h0;
  logic [3:0] f_ext = 4'h0, f_en = 4'h0;
  logic [7:0] b_ext = 8'h00, b_en = 8'h00;
  // external pull-up resistors on the open-drain lines
  logic [3:0] od_pu = 4'h0;
  int fail_count = 0;
  int n_checks = 0;

  always #2 sys_clk = ~sys_clk;

  pio_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_a_in(a_pin),
    .port_a_out(a_out), .port_a_oe(a_oe), .port_a_pullup(a_pu),
    .port_b_in(b_pin), .port_b_out(b_out), .port_b_oe(b_oe),
    .port_b_pullup(b_pu), .port_c_in(c_in), .port_d_in(d_in),
    .port_e_in(e_pin), .port_e_out(e_out), .port_e_oe(e_oe),
    .port_f_in(f_pin), .port_f_out(f_out), .port_f_oe(f_oe));
  pio_pin_model pins_a (.sys_clk(sys_clk),
    .out(a_out), .oe(a_oe), .pu(a_pu), .ext(a_ext), .ext_en(a_en),
    .pin(a_pin));
  pio_pin_model pins_b (.sys_clk(sys_clk),
    .out(b_out), .oe(b_oe), .pu(b_pu), .ext(b_ext), .ext_en(b_en),
    .pin(b_pin));
  pio_pin_model #(.W(4), .OD(1'b1)) pins_e (.sys_clk(sys_clk),
    .out(e_out), .oe(e_oe), .pu(od_pu), .ext(e_ext), .ext_en(e_en),
    .pin(e_pin));
  pio_pin_model #(.W(4), .OD(1'b1)) pins_f (.sys_clk(sys_clk),
    .out(f_out), .oe(f_oe), .pu(od_pu), .ext(f_ext), .ext_en(f_en),
    .pin(f_pin));

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] g,
    input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request moves right after a rising edge and stands until ready is seen
  // high at one; read data is taken at the edge that ends the data phase
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h0, d}, r);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, r, e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset;
    rd("dir_a", PIO_OFS_DIR_A, 32'h0);
    rd("dir_b", PIO_OFS_DIR_B, 32'h0);
    rd("dir_e", PIO_OFS_DIR_E, 32'h0);
    rd("dir_f", PIO_OFS_DIR_F, 32'h0);
    @(negedge sys_clk);
    chk("oe_a", 32'(a_oe), 32'h0);
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic s_port_a;
    @(posedge sys_clk);
    a_ext <= 8'ha5;
    a_en <= 8'hff;
    rd("in_a", PIO_OFS_PORT_A, 32'ha5);
    wr(PIO_OFS_PORT_A, 8'h3c);
    @(negedge sys_clk);
    chk("oe_a", 32'(a_oe), 32'h0);
    rd("in_a", PIO_OFS_PORT_A, 32'ha5);
    a_en <= 8'hf0;
    wr(PIO_OFS_DIR_A, 8'h0f);
    @(negedge sys_clk);
    chk("oe_a", 32'(a_oe), 32'h0f);
    chk("pin_a", 32'(a_pin), 32'hac);
    @(posedge sys_clk);
    a_en <= 8'hff;
    a_ext <= 8'h00;
    rd("load_a", PIO_OFS_PORT_A, 32'h0c);
    a_en <= 8'h00;
    wr(PIO_OFS_DIR_A, 8'h00);
    wr(PIO_OFS_DIR_A, 8'hff);
    @(negedge sys_clk);
    chk("pin_a", 32'(a_pin), 32'h3c);
    rd("latch_a", PIO_OFS_PORT_A, 32'h3c);
    wr(PIO_OFS_PORT_A, 8'h69);
    @(negedge sys_clk);
    chk("pin_a", 32'(a_pin), 32'h69);
  endtask

  task automatic s_pull;
    wr(PIO_OFS_DIR_A, 8'h00);
    wr(PIO_OFS_PULL_A, 8'h81);
    @(negedge sys_clk);
    chk("pu_a", 32'(a_pu), 32'h81);
    wr(PIO_OFS_DIR_A, 8'h01);
    @(negedge sys_clk);
    chk("pu_a", 32'(a_pu), 32'h80);
    wr(PIO_OFS_PULL_B, 8'h12);
    @(negedge sys_clk);
    chk("pu_b", 32'(b_pu), 32'hff);
    @(posedge sys_clk);
    b_ext <= 8'h05;
    b_en <= 8'h0f;
    rd("in_b", PIO_OFS_PORT_B, 32'hf5);
    b_en <= 8'h00;
    wr(PIO_OFS_DIR_B, 8'h0c);
    @(negedge sys_clk);
    chk("pu_b", 32'(b_pu), 32'hf3);
    wr(PIO_OFS_SERIAL, 8'h05);
    @(negedge sys_clk);
    chk("pu_b", 32'(b_pu), 32'h53);
    wr(PIO_OFS_PULL_B, 8'h10);
    @(negedge sys_clk);
    chk("pu_b", 32'(b_pu), 32'h50);
    wr(PIO_OFS_SERIAL, 8'h00);
    wr(PIO_OFS_PULL_B, 8'h00);
    @(negedge sys_clk);
    chk("pu_b", 32'(b_pu), 32'h00);
  endtask

  task automatic s_inonly;
    @(posedge sys_clk);
    c_in <= 8'h5a;
    d_in <= 4'h9;
    rd("in_c", PIO_OFS_PORT_C, 32'h5a);
    rd("in_d", PIO_OFS_PORT_D, 32'h09);
    wr(PIO_OFS_PORT_C, 8'hff);
    rd("in_c", PIO_OFS_PORT_C, 32'h5a);
    rd("unmapped", 8'hfc, 32'h0);
  endtask

  task automatic s_open;
    od_pu <= 4'hf;
    wr(PIO_OFS_PORT_E, 8'h05);
    wr(PIO_OFS_DIR_E, 8'h0f);
    @(negedge sys_clk);
    chk("oe_e", 32'(e_oe), 32'ha);
    chk("pin_e", 32'(e_pin), 32'h5);
    chk("out_e", 32'(e_out), 32'h0);
    wr(PIO_OFS_PORT_F, 8'h03);
    wr(PIO_OFS_DIR_F, 8'h0f);
    @(negedge sys_clk);
    chk("oe_f", 32'(f_oe), 32'hc);
    chk("pin_f", 32'(f_pin), 32'h3);
    rd("latch_f", PIO_OFS_PORT_F, 32'h03);
    e_en <= 4'hf;
    e_ext <= 4'hf;
    f_en <= 4'hf;
    f_ext <= 4'hf;
    wr(PIO_OFS_DIR_E, 8'h00);
    wr(PIO_OFS_DIR_F, 8'h00);
    wr(PIO_OFS_UPPER_CTRL, 8'h00);
    rd("in_e", PIO_OFS_PORT_E, 32'h03);
    rd("in_f", PIO_OFS_PORT_F, 32'h00);
    wr(PIO_OFS_UPPER_CTRL, 8'h01);
    rd("in_e", PIO_OFS_PORT_E, 32'h07);
    wr(PIO_OFS_UPPER_CTRL, 8'h3c);
    rd("in_e", PIO_OFS_PORT_E, 32'h03);
    rd("in_f", PIO_OFS_PORT_F, 32'h0f);
  endtask

  // ----------------------------------------
  // verdict and run control
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #40000;
    fail_count++;
    results;
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    s_reset;
    s_port_a;
    s_pull;
    s_inonly;
    s_open;
    results;
  end
endmodule
